/* src/ece_regs.vh */
// Constants for the EPP cycle engine: offsets, fields, resets and timing.
`ifndef ECE_REGS_VH
`define ECE_REGS_VH

// ----------------------------------------------------------------------
// Host port offsets
// ----------------------------------------------------------------------
`define ECE_HOFS_EPP_ADDR   3'h3
`define ECE_HOFS_EPP_DATA0  3'h4

// ----------------------------------------------------------------------
// Wishbone register byte offsets
// ----------------------------------------------------------------------
`define ECE_WB_CTRL         8'h00
`define ECE_WB_STATUS       8'h04
`define ECE_WB_MODE         8'h08
`define ECE_WB_RDATA        8'h0c

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define ECE_CTRL_STROBE     0
`define ECE_CTRL_AUTOFD     1
`define ECE_CTRL_INIT       2
`define ECE_CTRL_SLCTIN     3
`define ECE_CTRL_IRQE       4
`define ECE_CTRL_PCD        5
`define ECE_CTRL_RESET      6'h00

// ----------------------------------------------------------------------
// Status register fields (timeout and event rise are sticky, write 1 clears)
// ----------------------------------------------------------------------
`define ECE_ST_TIMEOUT      0
`define ECE_ST_STALL        1
`define ECE_ST_EVENT        2
`define ECE_ST_EVENT_RISE   3
`define ECE_ST_BUSY         4

// ----------------------------------------------------------------------
// Mode register fields and reset value
// ----------------------------------------------------------------------
`define ECE_MODE_EPP_EN     0
`define ECE_MODE_VER19      1
`define ECE_MODE_RESET      2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ECE_CLK_PERIOD_NS   5
`define ECE_TIMEOUT_NS      10000
`define ECE_TIMEOUT_CYC     (`ECE_TIMEOUT_NS / `ECE_CLK_PERIOD_NS)

`endif

/* src/ece_watchdog.v */
// Cycle watchdog: counts clocks while a cycle runs and flags an overrun.
`include "ece_regs.vh"

module ece_watchdog #(
    parameter CW   = 12,
    parameter TERM = `ECE_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire clk_in,
    input  wire reset_n_in,
    // Control
    input  wire run_in,
    // Result
    output reg  expire_out
);

    localparam [CW-1:0] TERM_W = TERM[CW-1:0];

    reg [CW-1:0] count_r;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Restarts whenever the cycle is not running; one pulse when the
    // count reaches the terminal value, then it holds until restarted.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_r    <= {CW{1'b0}};
            expire_out <= 1'b0;
        end else if (!run_in) begin
            count_r    <= {CW{1'b0}};
            expire_out <= 1'b0;
        end else if (count_r != TERM_W) begin
            count_r    <= count_r + 1'b1;
            expire_out <= (count_r == TERM_W - 1'b1);
        end else begin
            expire_out <= 1'b0;
        end
    end

endmodule

/* src/ece_cycle_engine.v */
// EPP cycle engine: host port, peripheral handshake and Wishbone registers.
//
// Operation
// [R01] Host starts 1.9 read with read strobe.
// [R02] 1.9 read holds host ready low.
// [R03] Stall low at strobe: finish on high.
// [R04] Stall high at start: wait low first.
// [R05] 1.9 read: float bus, drop qualifier, strobe.
// [R06] Peripheral drives data then raises stall.
// [R07] Capture byte, drop strobe, release ready.
// [R08] Peripheral floats bus, drops stall to end.
// [R09] Idle 1.7: outputs follow control register.
// [R10] 1.7 watchdog aborts after 10us, sets bit.
// [R11] Software sets control bits before cycles.
// [R12] 1.7 qualifier follows direction bit.
// [R13] 1.7 ready low while stall low.
// [R14] 1.7 write drives byte, latches at end.
// [R15] Data strobe for data, address for address.
// [R16] Stall high acknowledges, low means ready.
// [R17] Event input passed through, rising edge.
// [R18] Active low peripheral reset output.
// [R19] Direction high only for read or bit.
// [R20] 1.9 watchdog ends at stall deassertion.
// [R21] Offset 3 address cycles, 4-7 data.
// [R22] Strobe bit forces write direction.
// [R23] Watchdog is a device clock counter.
// [R24] Reset leaves engine idle and released.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`include "ece_regs.vh"

module ece_cycle_engine #(
    parameter TIMEOUT_CYC = `ECE_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        reset_n_in,
    // Wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    // Host port
    input  wire        host_ior_n_in,
    input  wire        host_iow_n_in,
    input  wire [2:0]  host_addr_in,
    input  wire [7:0]  host_bus_in,
    output reg  [7:0]  host_bus_out,
    output reg         host_bus_oe_out,
    output reg         iochrdy_out,
    // Peripheral port
    input  wire [7:0]  periph_bus_in,
    output reg  [7:0]  periph_bus_out,
    output reg         periph_bus_oe_out,
    input  wire        periph_stall_in,
    input  wire        periph_event_in,
    output reg         periph_event_out,
    output reg         data_strobe_n_out,
    output reg         addr_strobe_n_out,
    output reg         outbound_qualifier_n_out,
    output reg         bus_direction_out,
    output reg         periph_reset_n_out,
    output reg         strobe_n_out,
    output reg         autofd_n_out,
    output reg         slctin_n_out
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [5:0] S_IDLE  = 6'h01;
    localparam [5:0] S_WLO   = 6'h02;
    localparam [5:0] S_STB   = 6'h04;
    localparam [5:0] S_DONE  = 6'h08;
    localparam [5:0] S_C17   = 6'h10;
    localparam [5:0] S_ABORT = 6'h20;

    // True for the offsets that launch EPP cycles.
    function ece_epp_hit;
        input [2:0] a;
        begin
            ece_epp_hit = (a >= `ECE_HOFS_EPP_ADDR);
        end
    endfunction

    reg [5:0] state_r;
    reg [5:0] state_nxt;
    reg       cyc_rd_r;
    reg       cyc_rd_nxt;
    reg       cyc_addr_r;
    reg       cyc_addr_nxt;
    reg [5:0] ctrl_r;
    reg [1:0] mode_r;
    reg       timeout_r;
    reg       event_rise_r;
    reg       event_prev_r;
    reg [7:0] rdata_r;
    wire      wd_expire;
    wire      host_act;
    wire      wb_req;
    wire      wb_wr;
    wire      in_cyc_nxt;
    wire      strobe_nxt;
    wire      dir_nxt;
    wire      ver19;

    assign host_act   = !host_ior_n_in || !host_iow_n_in;
    assign ver19      = mode_r[`ECE_MODE_VER19];
    assign wb_req     = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wb_wr      = wb_req && wb_we_in && wb_sel_in[0];
    assign in_cyc_nxt = (state_nxt != S_IDLE);

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // [R23] device clock counter
    // [R10] [R20] runs over the timed span
    ece_watchdog #(
        .CW   (12),
        .TERM (TIMEOUT_CYC)
    ) u_wd (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .run_in     ((state_r == S_WLO) || (state_r == S_STB) ||
                     (state_r == S_C17)),
        .expire_out (wd_expire)
    );

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    // Chooses the next phase from the host strobes and the stall line.
    always @* begin
        state_nxt    = state_r;
        cyc_rd_nxt   = cyc_rd_r;
        cyc_addr_nxt = cyc_addr_r;
        case (state_r)
            S_IDLE: begin
                // [R01] [R21] host strobe launches cycle
                if (mode_r[`ECE_MODE_EPP_EN] && host_act &&
                    ece_epp_hit(host_addr_in)) begin
                    cyc_rd_nxt   = !host_ior_n_in;
                    cyc_addr_nxt = (host_addr_in == `ECE_HOFS_EPP_ADDR);
                    // [R04] wait for stall low first
                    if (!ver19)
                        state_nxt = S_C17;
                    else if (periph_stall_in)
                        state_nxt = S_WLO;
                    else
                        state_nxt = S_STB;
                end
            end
            S_WLO: begin
                if (wd_expire)
                    state_nxt = S_ABORT;
                else if (!periph_stall_in)
                    state_nxt = S_STB;
            end
            S_STB: begin
                // [R03] [R16] finish once stall rises
                if (wd_expire)
                    state_nxt = S_ABORT;
                else if (periph_stall_in)
                    state_nxt = S_DONE;
            end
            S_DONE: begin
                if (!host_act)
                    state_nxt = S_IDLE;
            end
            S_C17: begin
                // [R10] abort on overrun
                if (!host_act)
                    state_nxt = S_IDLE;
                else if (wd_expire)
                    state_nxt = S_ABORT;
            end
            S_ABORT: begin
                if (!host_act)
                    state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // Strobe is active while the peripheral phase of a cycle runs.
    assign strobe_nxt = (state_nxt == S_STB) || (state_nxt == S_C17);

    // [R19] [R22] direction high for 1.9 reads or set bit
    assign dir_nxt = (in_cyc_nxt && ver19) ?
                     ((cyc_rd_nxt || ctrl_r[`ECE_CTRL_PCD]) &&
                      !ctrl_r[`ECE_CTRL_STROBE]) :
                     (ctrl_r[`ECE_CTRL_PCD] &&
                      !(in_cyc_nxt && ctrl_r[`ECE_CTRL_STROBE]));

    // ------------------------------------------------------------------
    // Sequencer, peripheral and host outputs
    // ------------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            // [R24] idle with strobes off
            state_r                  <= S_IDLE;
            cyc_rd_r                 <= 1'b0;
            cyc_addr_r               <= 1'b0;
            data_strobe_n_out        <= 1'b1;
            addr_strobe_n_out        <= 1'b1;
            outbound_qualifier_n_out <= 1'b1;
            bus_direction_out        <= 1'b0;
            periph_bus_oe_out        <= 1'b0;
            periph_bus_out           <= 8'h00;
            iochrdy_out              <= 1'b1;
            host_bus_out             <= 8'h00;
            host_bus_oe_out          <= 1'b0;
            rdata_r                  <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            cyc_rd_r   <= cyc_rd_nxt;
            cyc_addr_r <= cyc_addr_nxt;
            // [R15] strobe chosen by register kind
            data_strobe_n_out <= !(strobe_nxt && !cyc_addr_nxt);
            addr_strobe_n_out <= !(strobe_nxt && cyc_addr_nxt);
            // [R05] [R12] qualifier tracks direction
            // [R04] held while a busy peripheral is awaited
            if (state_nxt != S_WLO) begin
                outbound_qualifier_n_out <= dir_nxt;
                bus_direction_out        <= dir_nxt;
                periph_bus_oe_out        <= !dir_nxt;
            end
            // [R14] drive host byte, hold it after
            if (in_cyc_nxt && !cyc_rd_nxt && !host_iow_n_in &&
                (state_nxt != S_DONE) && (state_nxt != S_ABORT))
                periph_bus_out <= host_bus_in;
            // [R02] [R13] hold host ready low
            iochrdy_out <= !((state_nxt == S_WLO) ||
                             (state_nxt == S_STB) ||
                             ((state_nxt == S_C17) && !periph_stall_in));
            // [R07] capture byte as strobe drops
            if (state_r == S_STB && state_nxt == S_DONE && cyc_rd_r) begin
                rdata_r      <= periph_bus_in;
                host_bus_out <= periph_bus_in;
            end else if (state_nxt == S_C17 && cyc_rd_nxt) begin
                rdata_r      <= periph_bus_in;
                host_bus_out <= periph_bus_in;
            end
            host_bus_oe_out <= cyc_rd_nxt && !host_ior_n_in &&
                               ((state_nxt == S_DONE) ||
                                (state_nxt == S_C17) ||
                                (state_nxt == S_ABORT));
        end
    end

    // ------------------------------------------------------------------
    // Plain port outputs
    // ------------------------------------------------------------------
    // [R09] [R18] [R17] control bits and event pass through
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            strobe_n_out       <= 1'b1;
            autofd_n_out       <= 1'b1;
            slctin_n_out       <= 1'b1;
            periph_reset_n_out <= 1'b0;
            periph_event_out   <= 1'b0;
            event_prev_r       <= 1'b0;
        end else begin
            strobe_n_out       <= !ctrl_r[`ECE_CTRL_STROBE];
            autofd_n_out       <= !ctrl_r[`ECE_CTRL_AUTOFD];
            slctin_n_out       <= !ctrl_r[`ECE_CTRL_SLCTIN];
            periph_reset_n_out <= ctrl_r[`ECE_CTRL_INIT];
            periph_event_out   <= periph_event_in;
            event_prev_r       <= periph_event_in;
        end
    end

    // ------------------------------------------------------------------
    // Wishbone registers
    // ------------------------------------------------------------------
    // Writes take effect in the cycle of the ack; sticky bits clear on a
    // written one, but a new event in the same cycle wins.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ctrl_r       <= `ECE_CTRL_RESET;
            mode_r       <= `ECE_MODE_RESET;
            timeout_r    <= 1'b0;
            event_rise_r <= 1'b0;
            wb_ack_out   <= 1'b0;
            wb_dat_out   <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_req;
            if (wb_wr && wb_adr_in == `ECE_WB_CTRL)
                ctrl_r <= wb_dat_in[5:0];
            if (wb_wr && wb_adr_in == `ECE_WB_MODE)
                mode_r <= wb_dat_in[1:0];
            // [R10] timeout flag, set wins
            if (wd_expire)
                timeout_r <= 1'b1;
            else if (wb_wr && wb_adr_in == `ECE_WB_STATUS &&
                     wb_dat_in[`ECE_ST_TIMEOUT])
                timeout_r <= 1'b0;
            // [R17] rising edge capture
            if (periph_event_in && !event_prev_r)
                event_rise_r <= 1'b1;
            else if (wb_wr && wb_adr_in == `ECE_WB_STATUS &&
                     wb_dat_in[`ECE_ST_EVENT_RISE])
                event_rise_r <= 1'b0;
            // Read data; unmapped offsets read as zero.
            if (wb_req) begin
                case (wb_adr_in)
                    `ECE_WB_CTRL:   wb_dat_out <= {26'h0, ctrl_r};
                    `ECE_WB_STATUS: wb_dat_out <= {27'h0,
                                                   (state_r != S_IDLE),
                                                   event_rise_r,
                                                   periph_event_in,
                                                   periph_stall_in,
                                                   timeout_r};
                    `ECE_WB_MODE:   wb_dat_out <= {30'h0, mode_r};
                    `ECE_WB_RDATA:  wb_dat_out <= {24'h0, rdata_r};
                    default:        wb_dat_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // [R06] [R08] [R11] peripheral and software keep their side
    // The engine relies on those parties and adds no checks of its own.

endmodule

/* test/ece_asserts.sv */
// Port checker for the EPP cycle engine.
module ece_asserts #(
    parameter TIMEOUT_CYC = 2000
) (
    // Clock and reset
    input wire       clk_in,
    input wire       reset_n_in,
    // Host side
    input wire       host_ior_n_in,
    input wire       host_iow_n_in,
    input wire [2:0] host_addr_in,
    input wire [7:0] host_bus_in,
    input wire [7:0] host_bus_out,
    input wire       host_bus_oe_out,
    input wire       iochrdy_out,
    // Peripheral side
    input wire [7:0] periph_bus_in,
    input wire [7:0] periph_bus_out,
    input wire       periph_bus_oe_out,
    input wire       periph_stall_in,
    input wire       periph_event_in,
    input wire       periph_event_out,
    input wire       data_strobe_n_out,
    input wire       addr_strobe_n_out,
    input wire       outbound_qualifier_n_out,
    input wire       bus_direction_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] lo_cnt_r = 12'h000;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Counts how long the host has been held off.
    always @(posedge clk_in) begin
        lo_cnt_r <= (!reset_n_in || iochrdy_out) ? 12'h000
                                                  : lo_cnt_r + 12'h001;
    end

    rst_idle_a: assert property (disable iff (1'b0) !reset_n_in |=>
        data_strobe_n_out && addr_strobe_n_out && iochrdy_out
        && !bus_direction_out) else $error("engine not idle after reset");
    addr_stb_a: assert property (!addr_strobe_n_out |->
        host_addr_in == 3'h3 && data_strobe_n_out)
        else $error("address strobe on a data offset");
    data_stb_a: assert property (!data_strobe_n_out |->
        host_addr_in[2]) else $error("data strobe on the address offset");
    rdy_hold_a: assert property (!data_strobe_n_out &&
        $past(data_strobe_n_out) == 1'b0 && $past(periph_stall_in) == 1'b0
        |-> !iochrdy_out) else $error("host released while stalled");
    wait_low_a: assert property ($fell(data_strobe_n_out) &&
        bus_direction_out |-> !$past(periph_stall_in))
        else $error("read strobe before stall went low");
    read_float_a: assert property (!data_strobe_n_out &&
        bus_direction_out |-> !periph_bus_oe_out && outbound_qualifier_n_out)
        else $error("bus driven during a read");
    rd_capture_a: assert property ($rose(data_strobe_n_out) &&
        $past(periph_stall_in) && !host_ior_n_in |-> iochrdy_out &&
        host_bus_oe_out && host_bus_out == $past(periph_bus_in))
        else $error("read byte not handed to host");
    wr_drive_a: assert property (!data_strobe_n_out &&
        !outbound_qualifier_n_out && !host_iow_n_in |-> periph_bus_oe_out
        && periph_bus_out == host_bus_in) else $error("write byte not driven");
    evt_pass_a: assert property ($rose(periph_event_in) |=>
        $rose(periph_event_out)) else $error("event not passed through");
    wdog_bound_a: assert property (
        lo_cnt_r <= TIMEOUT_CYC + 4)
        else $error("host held beyond the watchdog");
    wlo_qual_a: assert property (!iochrdy_out &&
        data_strobe_n_out && addr_strobe_n_out |->
        $stable(outbound_qualifier_n_out) && $stable(bus_direction_out))
        else $error("qualifier changed before stall went low");

    cover property ($rose(iochrdy_out) && host_bus_oe_out);
    cover property (lo_cnt_r == TIMEOUT_CYC);
    cover property (!addr_strobe_n_out && !outbound_qualifier_n_out);
endmodule

bind ece_cycle_engine ece_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .clk_in, .reset_n_in, .host_ior_n_in, .host_iow_n_in, .host_addr_in,
    .host_bus_in, .host_bus_out, .host_bus_oe_out, .iochrdy_out,
    .periph_bus_in, .periph_bus_out, .periph_bus_oe_out, .periph_stall_in,
    .periph_event_in, .periph_event_out, .data_strobe_n_out,
    .addr_strobe_n_out, .outbound_qualifier_n_out, .bus_direction_out
);

/* test/ece_periph_model.sv */
// Behavioural EPP peripheral that paces cycles with its stall line.
module ece_periph_model (
    // Engine side
    input  wire       clk_in,
    input  wire       data_strobe_n_in,
    input  wire       addr_strobe_n_in,
    input  wire       dir_in,
    input  wire [7:0] bus_in,
    input  wire       oe_in,
    // Pacing from the bench
    input  wire [3:0] delay_in,
    input  wire       hang_in,
    input  wire       pre_hi_in,
    input  wire [7:0] byte_in,
    // Answer
    output reg  [7:0] bus_out = 8'h00,
    output wire       stall_out,
    output reg  [7:0] got_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [3:0] cnt_r = 4'h0;
    reg        drv_r = 1'b0;
    reg        ack_r = 1'b0;
    wire       stb_w = !(data_strobe_n_in & addr_strobe_n_in);
    wire       go_w  = stb_w && !hang_in && cnt_r >= delay_in;

    assign stall_out = ack_r | pre_hi_in;

    // invert bus each clock when not driving and drop stall after strobe
    always @(posedge clk_in) begin
        cnt_r <= !stb_w ? 4'h0 : (cnt_r == 4'hf ? cnt_r : cnt_r + 4'h1);
        drv_r <= go_w && dir_in;
        ack_r <= go_w && (drv_r || !dir_in);
        bus_out <= (go_w && dir_in) ? byte_in : ~bus_out;
        if (stb_w && !dir_in && oe_in)
            got_out <= bus_in;
    end
endmodule

/* test/testbench.sv */
// Self-checking bench for the EPP cycle engine.
`include "ece_regs.vh"
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("Error %0t: got %h exp %h", $time, (g), (e)); \
    end \
end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam TO = 20;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, wb_cyc = 1'b0;
    logic        wb_stb = 1'b0, wb_we = 1'b0, evt = 1'b0, hang = 1'b0;
    logic        ior_n = 1'b1, iow_n = 1'b1, pre_hi = 1'b0;
    logic [7:0]  wb_adr = 8'h00, hbus = 8'h00, pbyte = 8'h00;
    logic [31:0] wb_wdat = 32'h0, seed = 32'h59986e4a;
    logic [2:0]  haddr = 3'h0;
    logic [3:0]  dly = 4'h0;
    int          failures = 0, total_checks = 0, cyc_cnt = 0;
    wire [31:0]  wb_rdat;
    wire [7:0]   hbus_o, pbus_o, pbus_i, got;
    wire         wb_ack, hoe, rdy, poe, stall, evt_o, dstb_n, astb_n;
    wire         qual_n, dir, prst_n, stb_n, afd_n, sin_n;

    ece_cycle_engine #(.TIMEOUT_CYC(TO)) u_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(4'hf), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
        .wb_ack_out(wb_ack), .host_ior_n_in(ior_n), .host_iow_n_in(iow_n),
        .host_addr_in(haddr), .host_bus_in(hbus), .host_bus_out(hbus_o),
        .host_bus_oe_out(hoe), .iochrdy_out(rdy), .periph_bus_in(pbus_i),
        .periph_bus_out(pbus_o), .periph_bus_oe_out(poe),
        .periph_stall_in(stall), .periph_event_in(evt),
        .periph_event_out(evt_o), .data_strobe_n_out(dstb_n),
        .addr_strobe_n_out(astb_n), .outbound_qualifier_n_out(qual_n),
        .bus_direction_out(dir), .periph_reset_n_out(prst_n),
        .strobe_n_out(stb_n), .autofd_n_out(afd_n), .slctin_n_out(sin_n));

    ece_periph_model u_per (
        .clk_in(clk_in), .data_strobe_n_in(dstb_n), .addr_strobe_n_in(astb_n),
        .dir_in(dir), .bus_in(pbus_o), .oe_in(poe), .delay_in(dly),
        .hang_in(hang), .pre_hi_in(pre_hi), .byte_in(pbyte),
        .bus_out(pbus_i), .stall_out(stall), .got_out(got));

    // Clock, event stimulus and hang limit.
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        evt <= cyc_cnt[3];
        if (cyc_cnt == 20000) begin
            failures++;
            results();
        end
    end

    // Next value of the xorshift sequence.
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Idle pin levels expected from a control value.
    function automatic [4:0] pins(input [5:0] c);
        return {c[5], c[2], ~c[3], ~c[1], ~c[0]};
    endfunction

    // One classic Wishbone cycle; waits for ack.
    task automatic wb(input [7:0] a, input w, input [31:0] d, output [31:0] q);
        int n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge clk_in); while (wb_ack !== 1'b1 && ++n < 40);
        q = wb_rdat;
        if (n >= 40) failures++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_in);
    endtask

    // One host port cycle held until ready returns.
    // host strobe and offset start each cycle
    task automatic host(input rd, input [2:0] a, input [7:0] d,
                        output [7:0] q);
        int n = 0;
        haddr <= a;
        hbus <= d;
        ior_n <= !rd;
        iow_n <= rd;
        do @(posedge clk_in); while ((n < 2 || rdy !== 1'b1) && ++n < 200);
        q = hbus_o;
        if (n >= 200) failures++;
        ior_n <= 1'b1;
        iow_n <= 1'b1;
        repeat (3) @(posedge clk_in);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        logic [31:0] r;
        logic [7:0]  q;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        `CHK({dstb_n, astb_n, rdy, dir, poe, prst_n}, 6'b111000)
        @(posedge clk_in);
        for (int i = 0; i < 3; i++) begin
            wb(8'(i * 8), 1'b0, 32'h0, r);
            `CHK(r, 32'h0)
        end
        ior_n <= 1'b0;
        haddr <= 3'h4;
        repeat (5) @(posedge clk_in);
        `CHK({rdy, dstb_n}, 2'b11)
        ior_n <= 1'b1;
        repeat (4) begin
            seed = xs(seed);
            wb(`ECE_WB_CTRL, 1'b1, {26'h0, seed[5:0]}, r);
            `CHK({dir, prst_n, sin_n, afd_n, stb_n}, pins(seed[5:0]))
        end
        wb(`ECE_WB_CTRL, 1'b1, 32'h4, r);
        wb(`ECE_WB_MODE, 1'b1, 32'h3, r);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            if (i == 8) wb(`ECE_WB_MODE, 1'b1, 32'h1, r);
            // direction bit set to suit each cycle
            if (i >= 8) wb(`ECE_WB_CTRL, 1'b1, {26'h0, seed[0], 5'h04}, r);
            pbyte <= seed[15:8];
            dly <= {1'b0, seed[18:16]};
            host(seed[0], seed[2:0] < 3 ? 3'h3 : seed[2:0], seed[31:24], q);
            if (seed[0]) `CHK(q, seed[15:8])
            else `CHK(got, seed[31:24])
            `CHK(dir, i >= 8 && seed[0])
        end
        wb(`ECE_WB_MODE, 1'b1, 32'h3, r);
        wb(`ECE_WB_CTRL, 1'b1, 32'h4, r);
        pre_hi <= 1'b1;
        pbyte <= 8'h5a;
        fork
            host(1'b1, 3'h4, 8'h00, q);
            begin
                repeat (6) @(posedge clk_in);
                `CHK({dstb_n, rdy, qual_n, dir}, 4'b1000)
                pre_hi <= 1'b0;
            end
        join
        `CHK(q, 8'h5a)
        wb(`ECE_WB_RDATA, 1'b0, 32'h0, r);
        `CHK(r, 32'h5a)
        hang <= 1'b1;
        for (int m = 1; m <= 3; m += 2) begin
            wb(`ECE_WB_MODE, 1'b1, m, r);
            wb(`ECE_WB_CTRL, 1'b1, m == 1 ? 32'h24 : 32'h04, r);
            host(1'b1, 3'h5, 8'h00, q);
            wb(`ECE_WB_STATUS, 1'b0, 32'h0, r);
            `CHK(r[0], 1'b1)
            wb(`ECE_WB_STATUS, 1'b1, 32'h1, r);
            wb(`ECE_WB_STATUS, 1'b0, 32'h0, r);
            `CHK(r[0], 1'b0)
        end
        results();
    end
endmodule
